// file: logic/slk_pkg.sv
/*
  Shared constants and types for the streaming link user-side pair.
  Assumes one 50 MHz clock shared by both ends.
*/
package slk_pkg;
  // Stream and error widths
  localparam int DATA_W = 64;
  localparam int ERR_W = 4;
  localparam int ERR_OVF = 0;
  localparam int ERR_SEU_FIX = 1;
  localparam int ERR_SEU_BAD = 2;
  localparam int ERR_GAP = 3;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int SEQ_NS = 1000;
  localparam int LINK_NS = 2000;
  localparam int SEQ_CYC = (SEQ_NS * CLK_MHZ + 999) / 1000;
  localparam int LINK_CYC = (LINK_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // Lane rate divider, one tick every LANE_DIV cycles
  localparam logic [1:0] LANE_DIV = 2'h2;
  // Adaptation FIFO
  localparam int FIFO_AW = 3;
  localparam logic [FIFO_AW:0] FIFO_DEPTH = 4'h8;
  // Idle cycles required between bursts
  localparam logic [7:0] BURST_GAP = 8'h02;
  // Register map, byte addresses
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] REG_STAT = 4'h4;
  localparam logic [ADR_W-1:0] REG_CLR = 4'h8;
  localparam logic [ADR_W-1:0] REG_RXCNT = 4'hC;
  // Control fields
  localparam int CTL_GO = 0;
  localparam int CTL_BURST = 1;
  localparam int CTL_ADV = 2;
  localparam int CTL_CRCEN = 3;
  localparam int CTL_INJ = 4;
  localparam int CTL_MRST = 5;
  localparam int CTL_IE_LSB = 8;
  localparam int CTL_LEN_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0004_0000;
  // Generator states
  typedef enum logic [1:0] {GEN_IDLE, GEN_RUN, GEN_GAP} slk_gen_t;
endpackage

// file: logic/slk_if.sv
/*
  Carrier between the link core end and the user logic end.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface slk_if;
  // Transmit stream
  logic [slk_pkg::DATA_W-1:0] txData;
  logic txValid;
  logic txReady;
  logic burstFirstWordFlag;
  logic burstLastWordFlag;
  logic txCrcInject;
  logic [slk_pkg::ERR_W-1:0] txError;
  logic txLinkUp;
  // Management
  logic burstMode;
  logic advancedMode;
  logic crcInjectEnable;
  logic mgmtReset;
  logic [slk_pkg::ERR_W-1:0] errIntEnable;
  logic [slk_pkg::ERR_W-1:0] errClear;
  logic [slk_pkg::ERR_W-1:0] errStatus;
  logic errInterrupt;
  // Receive side
  logic rxUserTick;
  logic rxUserReset;
  logic rxIfTick;
  logic rxIfReset;
  logic rxLinkUp;
  logic [slk_pkg::DATA_W-1:0] rxData;
  logic rxValid;
  logic rxFirst;
  logic rxLast;
  logic rxCrcError;

  modport dev (
    input txData, txValid, burstFirstWordFlag, burstLastWordFlag,
    input txCrcInject, burstMode, advancedMode, crcInjectEnable,
    input mgmtReset, errIntEnable, errClear,
    output txReady, txError, txLinkUp, errStatus, errInterrupt,
    output rxUserTick, rxUserReset, rxIfTick, rxIfReset, rxLinkUp,
    output rxData, rxValid, rxFirst, rxLast, rxCrcError
  );
  modport usr (
    output txData, txValid, burstFirstWordFlag, burstLastWordFlag,
    output txCrcInject, burstMode, advancedMode, crcInjectEnable,
    output mgmtReset, errIntEnable, errClear,
    input txReady, txError, txLinkUp, errStatus, errInterrupt,
    input rxUserTick, rxUserReset, rxIfTick, rxIfReset, rxLinkUp,
    input rxData, rxValid, rxFirst, rxLast, rxCrcError
  );
endinterface
`default_nettype wire

// file: logic/slk_device.sv
/*
  Link core end: transmit adaptation FIFO, error vector and sticky
  status with interrupt, receive clock enables, resets and link-up.
  Assumes the user end on the same clock drives the carrier.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Burst mode: first-word flag on first word
// - Continuous: first-word flag once at start
// - Burst mode: last-word flag on final word
// - Continuous: last-word flag optional, accepted both ways
// - Error bit 0 flags FIFO overflow
// - Error bit 1: corrected upset, ECC only; tied low here, never set
// - Error bit 2: uncorrectable upset, ECC only
// - Error bit 3: gap differs from set gap
// - Inject input forces CRC errors when enabled
// - Management enables injection before inject works
// - Interrupt high when enabled status bit set
// - Interrupt low once enabled bits all cleared
// - Standard mode: receive transfer tick output
// - Standard mode: receive reset for that domain
// - Receive user reset only in standard mode
// - Advanced mode: interface tick for transfers
// - Advanced: interface reset while management reset
// - Advanced: interface reset drops after sequence
// - Link ready once initialisation complete
// - User ignores receive data while link down
// - Ready only after transmit link up
module slk_device (
  input wire logic clk,
  input wire logic rst,
  input wire logic eccEnable,
  slk_if.dev link
);
  localparam int AW = slk_pkg::FIFO_AW;
  localparam int EW = slk_pkg::DATA_W + 4;

  ////////////////////////////////////////////////////////////////////
  // Reset sequence and link initialisation
  logic [slk_pkg::CNT_W-1:0] initCnt_q; // Cycles since reset
  logic seqDone; // Internal reset sequence finished
  logic linkDone; // Initialisation finished
  assign seqDone = initCnt_q >= slk_pkg::CNT_W'(slk_pkg::SEQ_CYC);
  assign linkDone = initCnt_q >= slk_pkg::CNT_W'(slk_pkg::LINK_CYC);

  // Counter restarts on management reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initCnt_q <= '0;
    end else if (link.mgmtReset) begin
      initCnt_q <= '0;
    end else if (!linkDone) begin
      initCnt_q <= initCnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Lane rate divider
  logic [1:0] divCnt_q; // Divider phase
  logic laneTick; // One-cycle lane rate enable
  assign laneTick = divCnt_q == slk_pkg::LANE_DIV - 2'h1;

  // Wraps at the lane divide ratio
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= laneTick ? 2'h0 : divCnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Adaptation FIFO: entry is parity, crc mark, last, first, data
  logic [EW-1:0] mem [2**AW]; // FIFO storage
  logic [AW-1:0] wrPtr_q; // Write pointer
  logic [AW-1:0] rdPtr_q; // Read pointer
  logic [AW:0] fill_q; // Words held
  logic txReady_q; // Registered ready
  logic push; // Word accepted
  logic pop; // Word sent to the lane
  logic injectNow; // Corrupt this word
  logic [EW-1:0] wrEntry; // Entry being written
  logic [EW-1:0] rdEntry; // Entry at head
  logic [AW:0] fillD; // Next fill level
  logic overflow; // Push attempt while full
  logic parityBad; // Head entry parity mismatch

  // Even parity over the stored word
  function automatic logic parity(input logic [EW-2:0] v);
    parity = ^v;
  endfunction

  assign push = link.txValid && txReady_q;
  assign pop = laneTick && (fill_q != '0);
  assign overflow = link.txValid && (fill_q == slk_pkg::FIFO_DEPTH);
  assign injectNow = link.txCrcInject && link.crcInjectEnable;
  assign wrEntry[EW-2:0] = {injectNow, link.burstLastWordFlag,
                            link.burstFirstWordFlag, link.txData};
  assign wrEntry[EW-1] = parity(wrEntry[EW-2:0]);
  assign rdEntry = mem[rdPtr_q];
  assign parityBad = parity(rdEntry[EW-2:0]) != rdEntry[EW-1];
  assign fillD = fill_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= wrEntry;
    end
  end

  // Pointers, fill and ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      fill_q <= '0;
      txReady_q <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      fill_q <= fillD;
      txReady_q <= linkDone && !link.mgmtReset &&
                   (fillD != slk_pkg::FIFO_DEPTH);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Burst gap check
  logic [7:0] gapCnt_q; // Idle cycles since last word
  logic gapOpen_q; // A burst has ended
  logic gapErr; // Gap mismatch on a first word
  assign gapErr = push && link.burstFirstWordFlag && gapOpen_q &&
                  link.burstMode && (gapCnt_q != slk_pkg::BURST_GAP);

  // Starts at burst_last_word_flag, saturates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapCnt_q <= '0;
      gapOpen_q <= 1'b0;
    end else if (push && link.burstLastWordFlag) begin
      gapCnt_q <= '0;
      gapOpen_q <= 1'b1;
    end else if (push && link.burstFirstWordFlag) begin
      gapOpen_q <= 1'b0;
    end else if (gapOpen_q && gapCnt_q != 8'hFF) begin
      gapCnt_q <= gapCnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Error vector, sticky status and interrupt
  logic [slk_pkg::ERR_W-1:0] errEvt; // This cycle's error events
  logic [slk_pkg::ERR_W-1:0] txError_q; // Error vector out
  logic [slk_pkg::ERR_W-1:0] errStatus_q; // Sticky status
  logic [slk_pkg::ERR_W-1:0] statusD; // Next status
  logic errInterrupt_q; // Interrupt level
  assign errEvt[slk_pkg::ERR_OVF] = overflow;
  assign errEvt[slk_pkg::ERR_SEU_FIX] = 1'b0;
  assign errEvt[slk_pkg::ERR_SEU_BAD] = pop && eccEnable && parityBad;
  assign errEvt[slk_pkg::ERR_GAP] = gapErr;
  assign statusD = (errStatus_q & ~link.errClear) | errEvt;

  // Events win over clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txError_q <= '0;
      errStatus_q <= '0;
      errInterrupt_q <= 1'b0;
    end else begin
      txError_q <= errEvt;
      errStatus_q <= statusD;
      errInterrupt_q <= |(statusD & link.errIntEnable);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive side outputs
  logic rxUserTick_q; // Standard mode transfer tick
  logic rxIfTick_q; // Advanced mode transfer tick
  logic rxUserReset_q; // Standard mode reset
  logic rxIfReset_q; // Advanced mode reset
  logic linkUp_q; // Link ready
  logic [slk_pkg::DATA_W-1:0] rxData_q; // Received word
  logic rxValid_q; // Word valid
  logic rxFirst_q; // First of burst
  logic rxLast_q; // Last of burst
  logic rxCrc_q; // Word has CRC error

  // Ticks and resets follow the clocking mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxUserTick_q <= 1'b0;
      rxIfTick_q <= 1'b0;
      rxUserReset_q <= 1'b1;
      rxIfReset_q <= 1'b1;
      linkUp_q <= 1'b0;
    end else begin
      rxUserTick_q <= laneTick && !link.advancedMode;
      rxIfTick_q <= laneTick && link.advancedMode;
      rxUserReset_q <= !link.advancedMode && !seqDone;
      rxIfReset_q <= link.advancedMode &&
                     (link.mgmtReset || !seqDone);
      linkUp_q <= linkDone && !link.mgmtReset;
    end
  end

  // Word delivered in its tick cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxData_q <= '0;
      rxValid_q <= 1'b0;
      rxFirst_q <= 1'b0;
      rxLast_q <= 1'b0;
      rxCrc_q <= 1'b0;
    end else begin
      rxValid_q <= pop;
      if (pop) begin
        rxData_q <= rdEntry[slk_pkg::DATA_W-1:0];
        rxFirst_q <= rdEntry[slk_pkg::DATA_W];
        rxLast_q <= rdEntry[slk_pkg::DATA_W+1];
        rxCrc_q <= rdEntry[slk_pkg::DATA_W+2];
      end else begin
        rxFirst_q <= 1'b0;
        rxLast_q <= 1'b0;
        rxCrc_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Carrier drive
  assign link.txReady = txReady_q;
  assign link.txError = txError_q;
  assign link.txLinkUp = linkUp_q;
  assign link.errStatus = errStatus_q;
  assign link.errInterrupt = errInterrupt_q;
  assign link.rxUserTick = rxUserTick_q;
  assign link.rxIfTick = rxIfTick_q;
  assign link.rxUserReset = rxUserReset_q;
  assign link.rxIfReset = rxIfReset_q;
  assign link.rxLinkUp = linkUp_q;
  assign link.rxData = rxData_q;
  assign link.rxValid = rxValid_q;
  assign link.rxFirst = rxFirst_q;
  assign link.rxLast = rxLast_q;
  assign link.rxCrcError = rxCrc_q;
endmodule // slk_device
`default_nettype wire

// file: logic/slk_user.sv
/*
  User logic end: Wishbone register slave, burst generator and
  receive counter. Assumes the link core end shares the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module slk_user (
  input wire logic clk,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [slk_pkg::ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  slk_if.usr link
);
  ////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic [31:0] ctrl_q; // Control register
  logic [slk_pkg::ERR_W-1:0] errClear_q; // One-cycle clear pulse
  logic [31:0] rxCount_q; // Good words received
  logic crcSeen_q; // CRC error seen
  logic wbAck_q; // Acknowledge
  logic [31:0] wbDatR_q; // Read data
  logic access; // New bus request
  logic [31:0] statWord; // Status read value
  logic [31:0] rdMux; // Read select
  logic [31:0] byteMask; // Write lanes
  assign access = wbCyc && wbStb && !wbAck_q;
  assign byteMask = {{8{wbSel[3]}}, {8{wbSel[2]}},
                     {8{wbSel[1]}}, {8{wbSel[0]}}};
  assign statWord = {24'h0, crcSeen_q, link.rxLinkUp, link.txLinkUp,
                     link.errInterrupt, link.errStatus};
  assign rdMux = (wbAdr == slk_pkg::REG_CTRL) ? ctrl_q :
                 (wbAdr == slk_pkg::REG_STAT) ? statWord :
                 (wbAdr == slk_pkg::REG_RXCNT) ? rxCount_q : 32'h0;

  // One-cycle answer, write takes effect at ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbAck_q <= 1'b0;
      wbDatR_q <= '0;
      ctrl_q <= slk_pkg::CTRL_RST;
      errClear_q <= '0;
    end else begin
      wbAck_q <= access;
      wbDatR_q <= access ? rdMux : 32'h0;
      errClear_q <= '0;
      if (access && wbWe && wbAdr == slk_pkg::REG_CTRL) begin
        ctrl_q <= (ctrl_q & ~byteMask) | (wbDatW & byteMask);
      end
      if (access && wbWe && wbAdr == slk_pkg::REG_CLR && wbSel[0]) begin
        errClear_q <= wbDatW[slk_pkg::ERR_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stream generator
  slk_pkg::slk_gen_t state_q; // Generator state
  logic [63:0] data_q; // Word payload
  logic valid_q; // Word offered
  logic first_q; // First-word flag
  logic last_q; // Last-word flag
  logic [7:0] idx_q; // Word index in burst
  logic [7:0] gap_q; // Idle cycles waited
  logic go; // Sending enabled
  logic burst; // Burst mode
  logic take; // Word accepted
  logic [7:0] len; // Burst length
  logic lastNext; // Following word ends burst
  assign go = ctrl_q[slk_pkg::CTL_GO] && link.txLinkUp;
  assign burst = ctrl_q[slk_pkg::CTL_BURST];
  assign len = ctrl_q[slk_pkg::CTL_LEN_LSB +: 8];
  assign take = valid_q && link.txReady;
  assign lastNext = burst ? (idx_q + 8'h2 >= len) : !go;

  // Offers words, flags and inter-burst gaps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= slk_pkg::GEN_IDLE;
      data_q <= '0;
      valid_q <= 1'b0;
      first_q <= 1'b0;
      last_q <= 1'b0;
      idx_q <= '0;
      gap_q <= '0;
    end else begin
      unique case (state_q)
        slk_pkg::GEN_IDLE: begin
          if (go) begin
            state_q <= slk_pkg::GEN_RUN;
            valid_q <= 1'b1;
            first_q <= 1'b1;
            last_q <= burst && len <= 8'h1;
            idx_q <= '0;
          end
        end
        slk_pkg::GEN_RUN: begin
          if (take) begin
            data_q <= data_q + 64'h1;
            idx_q <= idx_q + 8'h1;
            first_q <= 1'b0;
            last_q <= lastNext;
            if (last_q) begin
              valid_q <= 1'b0;
              gap_q <= '0;
              state_q <= burst ? slk_pkg::GEN_GAP : slk_pkg::GEN_IDLE;
            end
          end
        end
        slk_pkg::GEN_GAP: begin
          gap_q <= gap_q + 8'h1;
          if (gap_q + 8'h2 >= slk_pkg::BURST_GAP) begin // Idle adds one
            state_q <= slk_pkg::GEN_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive counter
  logic rxTick; // Transfer tick of current mode
  logic rxGood; // Word counted
  assign rxTick = link.advancedMode ? link.rxIfTick : link.rxUserTick;
  assign rxGood = rxTick && link.rxValid && link.rxLinkUp;

  // Counts words only while link is up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxCount_q <= '0;
      crcSeen_q <= 1'b0;
    end else begin
      if (rxGood) begin
        rxCount_q <= rxCount_q + 32'h1;
      end
      if (rxGood && link.rxCrcError) begin
        crcSeen_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Carrier and bus drive
  assign wbAck = wbAck_q;
  assign wbDatR = wbDatR_q;
  assign link.txData = data_q;
  assign link.txValid = valid_q;
  assign link.burstFirstWordFlag = first_q;
  assign link.burstLastWordFlag = last_q;
  assign link.txCrcInject = ctrl_q[slk_pkg::CTL_INJ];
  assign link.crcInjectEnable = ctrl_q[slk_pkg::CTL_CRCEN];
  assign link.burstMode = ctrl_q[slk_pkg::CTL_BURST];
  assign link.advancedMode = ctrl_q[slk_pkg::CTL_ADV];
  assign link.mgmtReset = ctrl_q[slk_pkg::CTL_MRST];
  assign link.errIntEnable = ctrl_q[slk_pkg::CTL_IE_LSB +: slk_pkg::ERR_W];
  assign link.errClear = errClear_q;
endmodule // slk_user
`default_nettype wire

// file: tb/slk_chk.sv
/*
  Concurrent checks on the carrier between the two link ends.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module slk_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic txLinkUp,
  input wire logic [slk_pkg::ERR_W-1:0] txError,
  input wire logic advancedMode,
  input wire logic mgmtReset,
  input wire logic [slk_pkg::ERR_W-1:0] errIntEnable,
  input wire logic [slk_pkg::ERR_W-1:0] errClear,
  input wire logic [slk_pkg::ERR_W-1:0] errStatus,
  input wire logic errInterrupt,
  input wire logic rxUserTick,
  input wire logic rxIfTick,
  input wire logic rxUserReset,
  input wire logic rxIfReset,
  input wire logic rxLinkUp
);
  ////////////////////////////////////////////////////////////////////
  // Helper logic
  logic [7:0] seqCnt_q; // Cycles since reset or management reset
  logic [7:0] seqCnt_d;
  logic adv1_q; // Mode one cycle ago
  logic adv2_q; // Mode two cycles ago
  logic modeHeld; // Mode unchanged for two cycles
  assign seqCnt_d = mgmtReset ? 8'h00 :
                    seqCnt_q + {7'h00, seqCnt_q != 8'hFF};
  assign modeHeld = (advancedMode == adv1_q) && (adv1_q == adv2_q);
  // Counter and mode history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seqCnt_q <= 8'h00;
      adv1_q <= 1'b0;
      adv2_q <= 1'b0;
    end else begin
      seqCnt_q <= seqCnt_d;
      adv1_q <= advancedMode;
      adv2_q <= adv1_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  // Assertions
  ready_after_link_a: assert property (txReady |-> txLinkUp)
    else $error("ready high while transmit link down");
  ovf_cause_a: assert property (txError[slk_pkg::ERR_OVF] |->
    $past(txValid && !txReady)) else $error("overflow without refusal");
  err_latch_a: assert property (((~$past(txError)) |
    $past(errClear) | errStatus) == 4'hF)
    else $error("error pulse not latched in status");
  sticky_status_a: assert property ($past(mgmtReset) ||
    (($past(errStatus) & ~$past(errClear) & ~errStatus) == 4'h0))
    else $error("status bit dropped without clear");
  int_set_a: assert property ((|(errStatus & errIntEnable)) &&
    $stable(errIntEnable) |-> errInterrupt)
    else $error("interrupt low with enabled status");
  int_clr_a: assert property (!(|(errStatus & errIntEnable)) &&
    $stable(errIntEnable) |-> !errInterrupt)
    else $error("interrupt high with no enabled status");
  tick_pulse_a: assert property ((rxUserTick || rxIfTick) |=>
    !(rxUserTick || rxIfTick)) else $error("tick longer than a cycle");
  tick_mode_a: assert property (modeHeld |->
    !(advancedMode ? rxUserTick : rxIfTick))
    else $error("tick of the inactive mode");
  usr_rst_mode_a: assert property (modeHeld && advancedMode |->
    !rxUserReset) else $error("user reset in advanced mode");
  usr_rst_seq_a: assert property (modeHeld && !advancedMode |->
    (seqCnt_q inside {[3:slk_pkg::SEQ_CYC-3]} ? rxUserReset :
     (seqCnt_q > slk_pkg::SEQ_CYC + 2 ? !rxUserReset : 1'b1)))
    else $error("user reset out of sequence");
  if_rst_mgmt_a: assert property (advancedMode && mgmtReset &&
    $past(advancedMode && mgmtReset) |-> rxIfReset)
    else $error("interface reset low during management reset");
  if_rst_done_a: assert property (modeHeld && advancedMode &&
    seqCnt_q > slk_pkg::SEQ_CYC + 2 |-> !rxIfReset)
    else $error("interface reset stuck after sequence");
  link_time_a: assert property ($rose(rxLinkUp) |->
    seqCnt_q >= slk_pkg::LINK_CYC - 2) else $error("link up too early");
  link_drop_a: assert property (mgmtReset |-> ##[0:2] !rxLinkUp)
    else $error("link up during management reset");
  ////////////////////////////////////////////////////////////////////
  // Coverage
  gap_err_c: cover property (txError[slk_pkg::ERR_GAP]);
  int_rise_c: cover property ($rose(errInterrupt));
  adv_tick_c: cover property (rxIfTick && advancedMode);
  link_up_c: cover property ($rose(rxLinkUp));
endmodule // slk_chk
`default_nettype wire

// file: tb/testbench.sv
/*
  Top bench: both link ends joined, Wishbone register sequences.
  Assumes the register map and timing of the shared package.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic clk, rst, eccEnable, wbCyc, wbStb, wbWe, wbAck;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] wbDatW, wbDatR, rd;
  int error_cnt, checks, cyc, taken, firsts, lasts, bWords, lastLen;
  int idle, minGap, n, ifT, usT, f0, l0;
  slk_if link();
  slk_device u_slk_device (.clk(clk), .rst(rst), .eccEnable(eccEnable),
    .link(link.dev));
  slk_user u_slk_user (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .link(link.usr));
  slk_chk u_slk_chk (.clk(clk), .rst(rst), .txValid(link.txValid),
    .txReady(link.txReady), .txLinkUp(link.txLinkUp),
    .txError(link.txError), .advancedMode(link.advancedMode),
    .mgmtReset(link.mgmtReset), .errIntEnable(link.errIntEnable),
    .errClear(link.errClear), .errStatus(link.errStatus),
    .errInterrupt(link.errInterrupt), .rxUserTick(link.rxUserTick),
    .rxIfTick(link.rxIfTick), .rxUserReset(link.rxUserReset),
    .rxIfReset(link.rxIfReset), .rxLinkUp(link.rxLinkUp));
  ////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  always #10 clk = ~clk;
  // Stream monitor: words, flags, burst lengths, idle gaps
  always @(posedge clk) begin
    cyc++;
    if (link.txValid === 1'b1 && link.txReady === 1'b1) begin
      taken++;
      if (link.burstFirstWordFlag === 1'b1) begin
        if (lasts > 0 && idle < minGap) minGap = idle;
        firsts++;
        bWords = 0;
      end
      bWords++;
      if (link.burstLastWordFlag === 1'b1) begin
        lasts++;
        lastLen = bWords;
        idle = 0;
      end
    end else idle++;
  end
  ////////////////////////////////////////////////////////////////////
  // One Wishbone classic cycle, waits for ack
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we;
    wbAdr <= a; wbSel <= 4'hF; wbDatW <= d;
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    rd = wbDatR;
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    @(posedge clk);
  endtask
  // Read register and compare under a mask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd & m)
  endtask
  // Count ticks of each mode over 20 cycles
  task automatic ticks();
    ifT = 0; usT = 0;
    repeat (20) begin
      @(posedge clk);
      ifT += int'(link.rxIfTick === 1'b1);
      usT += int'(link.rxUserTick === 1'b1);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog on hangs
  initial begin
    #(20 * 30000);
    error_cnt++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 0; rst = 1; eccEnable = 1; wbCyc = 0; wbStb = 0; wbWe = 0;
    wbAdr = 4'h0; wbSel = 4'h0; wbDatW = 32'h0; minGap = 1000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrlReset", slk_pkg::REG_CTRL, 32'hFFFF_FFFF, slk_pkg::CTRL_RST);
    wb(1'b1, slk_pkg::REG_STAT, 32'h0000_00FF);
    rchk("statRo", slk_pkg::REG_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1'b1, 4'h1, 32'hFFFF_FFFF);
    rchk("unmapped", 4'h1, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("Test reset done");
    n = 0;
    do begin wb(1'b0, slk_pkg::REG_STAT, 32'h0); n++; end
    while (rd[6:5] !== 2'h3 && n < 100);
    `CHK("linkTime", 1'b1, cyc >= slk_pkg::LINK_CYC)
    `CHK("linkStat", 32'h0000_0060, rd)
    `CHK("userRst", 1'b0, link.rxUserReset)
    ticks();
    `CHK("stdTicks", 10, usT)
    `CHK("advTicksOff", 0, ifT)
    $display("Test link up done");
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0003);
    repeat (16) @(posedge clk);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0002);
    repeat (80) @(posedge clk);
    `CHK("burstLen", 4, lastLen)
    `CHK("flagPairs", firsts, lasts)
    `CHK("gapKept", 1'b1, minGap >= int'(slk_pkg::BURST_GAP))
    rchk("rxCount", slk_pkg::REG_RXCNT, 32'hFFFF_FFFF, taken);
    rchk("noErr", slk_pkg::REG_STAT, 32'h0000_001F, 32'h0);
    $display("Test burst done");
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0803);
    repeat (30) @(posedge clk);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0802);
    repeat (60) @(posedge clk);
    rchk("gapInt", slk_pkg::REG_STAT, 32'h0000_0018, 32'h18);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0002);
    rchk("masked", slk_pkg::REG_STAT, 32'h0000_0018, 32'h08);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0802);
    wb(1'b1, slk_pkg::REG_CLR, 32'h0000_000F);
    rchk("cleared", slk_pkg::REG_STAT, 32'h0000_001F, 32'h0);
    $display("Test gap error done");
    f0 = firsts; l0 = lasts;
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0001);
    repeat (60) @(posedge clk);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0000);
    repeat (80) @(posedge clk);
    `CHK("contFirst", 1, firsts - f0)
    `CHK("contLast", 1, lasts - l0)
    rchk("contCount", slk_pkg::REG_RXCNT, 32'hFFFF_FFFF, taken);
    $display("Test continuous done");
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0011);
    repeat (30) @(posedge clk);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0000);
    repeat (60) @(posedge clk);
    rchk("injOff", slk_pkg::REG_STAT, 32'h0000_0080, 32'h0);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0019);
    repeat (30) @(posedge clk);
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0008);
    repeat (60) @(posedge clk);
    rchk("injOn", slk_pkg::REG_STAT, 32'h0000_0080, 32'h80);
    $display("Test crc inject done");
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0004);
    ticks();
    `CHK("advTicks", 10, ifT)
    `CHK("stdTicksOff", 0, usT)
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0024);
    repeat (5) @(posedge clk);
    `CHK("ifRstMgmt", 1'b1, link.rxIfReset)
    `CHK("linkDrop", 1'b0, link.rxLinkUp)
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0004);
    n = 0;
    while (link.rxIfReset !== 1'b0 && n < 200) begin @(posedge clk); n++; end
    `CHK("ifRstSeq", 1'b1, (n - slk_pkg::SEQ_CYC) inside {[-6:2]})
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0020);
    repeat (5) @(posedge clk);
    `CHK("usrRstMgmt", 1'b1, link.rxUserReset)
    wb(1'b1, slk_pkg::REG_CTRL, 32'h0004_0000);
    repeat (120) @(posedge clk);
    `CHK("usrRstDone", 1'b0, link.rxUserReset)
    `CHK("relink", 1'b1, link.rxLinkUp)
    $display("Test clock modes done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
